// file: logic/sacr_top.sv
// Sample FIFO and conversion-and-readout handshake of the parallel-bus converter
// What this block does
// - Busy rises within 45 ns of start fall
// - Busy high no longer than 1.4 us of enabled clock cycles; cycles with clock enable low add to it
// - Busy drops within 20 ns of conversion end
// - Second start fall with select low, or select fall, aborts, windowed
// - New result on bus 30 ns after busy
// - Width or byte change drives new lanes fast
// - Read or select rise releases bus quickly
// - Busy high exactly while converting
// - Select fall acquires, start fall holds
// - Select and read low drive last result
`timescale 1ns/10ps
`default_nettype none
`include "sacr_regs.svh"

module sacr_fifo #(
  parameter int W = `SACR_WORD_W,
  parameter int DEPTH = `SACR_FIFO_DEPTH
) (
  input wire logic i_clk, // Core clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic i_ce, // Clock enable
  input wire logic i_wr_valid, // Write word offered
  output logic o_wr_ready, // Room for a word
  input wire logic [W-1:0] i_wr_data, // Write word
  output logic o_rd_valid, // Word available
  input wire logic i_rd_ready, // Reader takes word
  output logic [W-1:0] o_rd_data // Head word
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign push = i_wr_valid && o_wr_ready;
  assign pop = i_rd_ready && o_rd_valid;
  assign o_rd_data = mem[rd_ptr];

  always_comb
  begin
    next_count = count;
    if (push && !pop)
      next_count = count + 1'b1;
    else if (pop && !push)
      next_count = count - 1'b1;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_ce && push)
      mem[wr_ptr] <= i_wr_data;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      o_wr_ready <= 1'b1;
      o_rd_valid <= 1'b0;
    end
    else if (i_ce)
    begin
      if (push)
        wr_ptr <= AW'(wr_ptr + 1'b1);
      if (pop)
        rd_ptr <= AW'(rd_ptr + 1'b1);
      count <= next_count;
      // Flags registered so the top sees flop outputs
      o_wr_ready <= next_count != (AW+1)'(DEPTH);
      o_rd_valid <= next_count != '0;
    end
  end
endmodule : sacr_fifo

module sacr_top #(
  parameter int CONV_CYC = `SACR_CONV_CYC,
  parameter int ABORT_MIN_CYC = `SACR_ABORT_MIN_CYC,
  parameter int ABORT_MAX_CYC = `SACR_ABORT_MAX_CYC,
  parameter int FIFO_DEPTH = `SACR_FIFO_DEPTH
) (
  input wire logic i_clk, // Core clock, 250 MHz
  input wire logic i_rst_n, // Async reset, active low
  input wire logic i_ce, // Clock enable, freezes all state
  input wire logic i_conversion_start_n, // Start strobe pin
  input wire logic i_cs_n, // Chip select pin
  input wire logic i_rd_n, // Read strobe pin
  input wire logic i_bus_width_select, // Two-low-bit lane select pin
  input wire logic i_byte_select, // Byte fold select pin
  input wire logic i_sample_valid, // Sampled word offered
  input wire logic [`SACR_WORD_W-1:0] i_sample_data, // Sampled word
  output logic o_sample_ready, // FIFO has room
  output logic o_busy, // Conversion in progress
  output logic o_acquiring, // Acquisition phase
  output logic [`SACR_WORD_W-1:0] o_data, // Data bus value
  output logic o_data_oe // Data bus driven
);
  localparam int W = `SACR_WORD_W;
  localparam int CW = 11;
  localparam int RISE_MAX = `SACR_BUSY_RISE_CYC - 2;
  localparam int FALL_MAX = `SACR_BUSY_FALL_CYC;
  localparam int MSB_MAX = `SACR_MSB_VALID_CYC;
  localparam int TURN_MAX = `SACR_BUS_TURN_CYC - 2;
  localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYC - 1);
  localparam logic [CW-1:0] AB_LO = CW'(ABORT_MIN_CYC - 1);
  localparam logic [CW-1:0] AB_HI = CW'(ABORT_MAX_CYC - 1);

  // Lane map: all unselected lanes read as ones
  function automatic logic [W-1:0] lanes(input logic [W-1:0] d, input logic wide,
                                         input logic fold);
    logic [W-1:0] v;
    v = `SACR_ALL_ONES;
    case ({wide, fold})
      2'h0: v = d;
      2'h1: v[17:10] = d[9:2];
      2'h2: v[3:2] = d[1:0];
      default: v[11:10] = d[1:0];
    endcase
    return v;
  endfunction : lanes

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pin_s1;
  logic [4:0] pin_s2;
  logic [1:0] pin_prev;
  logic start_s;
  logic cs_s;
  logic rd_s;
  logic wide_s;
  logic fold_s;
  logic start_fall;
  logic cs_fall;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pin_s1 <= 5'h07;
      pin_s2 <= 5'h07;
      pin_prev <= 2'h3;
    end
    else if (i_ce)
    begin
      pin_s1 <= {i_byte_select, i_bus_width_select, i_rd_n, i_cs_n, i_conversion_start_n};
      pin_s2 <= pin_s1;
      pin_prev <= pin_s2[1:0];
    end
  end

  assign {fold_s, wide_s, rd_s, cs_s, start_s} = pin_s2;
  assign start_fall = pin_prev[0] && !start_s;
  assign cs_fall = pin_prev[1] && !cs_s;

  // ----------------------------------------------------------------
  // Sample FIFO
  // ----------------------------------------------------------------
  logic smp_valid;
  logic smp_take;
  logic [W-1:0] smp_data;

  sacr_fifo #(.W(W), .DEPTH(FIFO_DEPTH)) sacr_fifo_inst (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_wr_valid(i_sample_valid),
    .o_wr_ready(o_sample_ready),
    .i_wr_data(i_sample_data),
    .o_rd_valid(smp_valid),
    .i_rd_ready(smp_take),
    .o_rd_data(smp_data)
  );

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  sacr_pkg::sacr_state_e state;
  sacr_pkg::sacr_state_e next_state;
  logic [CW-1:0] cnt;
  logic begin_conv;
  logic in_window;
  logic abort;
  logic conv_done;
  logic [W-1:0] work;
  logic [W-1:0] result;

  assign begin_conv = start_fall && (state != sacr_pkg::SACR_CONV);
  assign in_window = (cnt >= AB_LO) && (cnt <= AB_HI);
  // Edges outside the window are ignored; a late edge cannot corrupt a result
  assign abort = (state == sacr_pkg::SACR_CONV) && in_window
               && ((start_fall && !cs_s) || cs_fall);
  assign conv_done = (state == sacr_pkg::SACR_CONV) && !abort && (cnt == CONV_LAST);
  // The sampled word is taken from the FIFO only at hold start, so it can fill
  assign smp_take = begin_conv && smp_valid;

  always_comb
  begin
    next_state = state;
    case (state)
      sacr_pkg::SACR_IDLE:
      begin
        if (begin_conv)
          next_state = sacr_pkg::SACR_CONV;
        else if (cs_fall)
          next_state = sacr_pkg::SACR_ACQ;
      end
      sacr_pkg::SACR_ACQ:
      begin
        if (begin_conv)
          next_state = sacr_pkg::SACR_CONV;
      end
      sacr_pkg::SACR_CONV:
      begin
        if (abort && cs_fall)
          next_state = sacr_pkg::SACR_ACQ;
        else if (abort || conv_done)
          next_state = sacr_pkg::SACR_IDLE;
      end
      default: next_state = sacr_pkg::SACR_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state <= sacr_pkg::SACR_IDLE;
      o_busy <= 1'b0;
      o_acquiring <= 1'b0;
    end
    else if (i_ce)
    begin
      state <= next_state;
      o_busy <= next_state == sacr_pkg::SACR_CONV;
      o_acquiring <= next_state == sacr_pkg::SACR_ACQ;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cnt <= '0;
    else if (i_ce)
    begin
      if (begin_conv)
        cnt <= '0;
      else if (state == sacr_pkg::SACR_CONV)
        cnt <= CW'(cnt + 1'b1);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      work <= '0;
      result <= '0;
    end
    else if (i_ce)
    begin
      // Empty FIFO repeats the previous sample rather than stalling the conversion
      if (smp_take)
        work <= smp_data;
      if (conv_done)
        result <= work;
    end
  end

  // ----------------------------------------------------------------
  // Parallel readout
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_data <= `SACR_ALL_ONES;
      o_data_oe <= 1'b0;
    end
    else if (i_ce)
    begin
      o_data <= lanes(result, wide_s, fold_s);
      o_data_oe <= !cs_s && !rd_s;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence conv_starts;
    begin_conv;
  endsequence

  sequence conv_finishes;
    conv_done ##1 !o_busy;
  endsequence

  chk_busy_rise: assert property (@(posedge i_clk) disable iff (!i_rst_n || !i_ce)
    conv_starts |-> ##[1:RISE_MAX] o_busy)
    else $error("busy did not rise after start");

  logic [CW-1:0] busy_len;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      busy_len <= '0;
    else if (i_ce)
      busy_len <= o_busy ? CW'(busy_len + 1'b1) : '0;
  end

  chk_busy_len_max: assert property (@(posedge i_clk) disable iff (!i_rst_n || !i_ce)
    o_busy |-> busy_len < CW'(CONV_CYC))
    else $error("busy held past conversion time");

  chk_busy_fall: assert property (@(posedge i_clk) disable iff (!i_rst_n || !i_ce)
    conv_done |-> ##[1:FALL_MAX] !o_busy)
    else $error("busy late to fall");

  chk_busy_state: assert property (@(posedge i_clk) disable iff (!i_rst_n || !i_ce)
    $rose(o_busy) |-> $past(begin_conv))
    else $error("busy rose without a conversion start");

  chk_abort_ends: assert property (@(posedge i_clk) disable iff (!i_rst_n || !i_ce)
    abort |=> !o_busy && $stable(result))
    else $error("abort did not stop conversion");

  chk_result_lands: assert property (@(posedge i_clk) disable iff (!i_rst_n || !i_ce)
    conv_finishes |-> ##[0:MSB_MAX] o_data == lanes(result, wide_s, fold_s))
    else $error("new result not on bus in time");

  chk_acq_entry: assert property (@(posedge i_clk) disable iff (!i_rst_n || !i_ce)
    (cs_fall && state == sacr_pkg::SACR_IDLE && !start_fall) |=> o_acquiring)
    else $error("select fall did not start acquisition");

  chk_bus_drive: assert property (@(posedge i_clk) disable iff (!i_rst_n || !i_ce)
    (!i_cs_n && !i_rd_n)[*4] |-> o_data_oe)
    else $error("bus not driven during read");

  chk_bus_release: assert property (@(posedge i_clk) disable iff (!i_rst_n || !i_ce)
    $rose(rd_s) |-> ##[1:TURN_MAX] !o_data_oe)
    else $error("bus not released");

  chk_lane_select: assert property (@(posedge i_clk) disable iff (!i_rst_n || !i_ce)
    ($changed(wide_s) || $changed(fold_s)) |=> o_data == lanes($past(result), $past(wide_s),
                                                          $past(fold_s)))
    else $error("lanes not updated after select change");
endmodule : sacr_top

`default_nettype wire

// file: shared/sacr_regs.svh
// Timing figures and derived cycle counts for the converter handshake block
`ifndef SACR_REGS_SVH
`define SACR_REGS_SVH
`define SACR_CLK_NS 4.0
`define SACR_T_CONV_US 1.4
`define SACR_T_BUSY_RISE_NS 45.0
`define SACR_T_BUSY_FALL_NS 20.0
`define SACR_T_MSB_VALID_NS 30.0
`define SACR_T_BUS_TURN_NS 20.0
`define SACR_T_ABORT_MIN_NS 65.0
`define SACR_T_ABORT_MAX_NS 1000.0
// Longest times round down, least times round up; small bias absorbs float error
`define SACR_CONV_CYC $rtoi(`SACR_T_CONV_US * 1000.0 / `SACR_CLK_NS + 0.001)
`define SACR_BUSY_RISE_CYC $rtoi(`SACR_T_BUSY_RISE_NS / `SACR_CLK_NS + 0.001)
`define SACR_BUSY_FALL_CYC $rtoi(`SACR_T_BUSY_FALL_NS / `SACR_CLK_NS + 0.001)
`define SACR_MSB_VALID_CYC $rtoi(`SACR_T_MSB_VALID_NS / `SACR_CLK_NS + 0.001)
`define SACR_BUS_TURN_CYC $rtoi(`SACR_T_BUS_TURN_NS / `SACR_CLK_NS + 0.001)
`define SACR_ABORT_MIN_CYC $rtoi($ceil(`SACR_T_ABORT_MIN_NS / `SACR_CLK_NS - 0.001))
`define SACR_ABORT_MAX_CYC $rtoi(`SACR_T_ABORT_MAX_NS / `SACR_CLK_NS + 0.001)
`define SACR_WORD_W 18
`define SACR_FIFO_DEPTH 16
`define SACR_ALL_ONES 18'h3FFFF
`endif

// file: shared/sacr_pkg.sv
// Types shared by the converter handshake block
`default_nettype none
package sacr_pkg;
  typedef enum logic [1:0]
  {
    SACR_IDLE = 2'h0,
    SACR_ACQ = 2'h1,
    SACR_CONV = 2'h3
  } sacr_state_e;
endpackage : sacr_pkg
`default_nettype wire

// file: verification/sacr_host.sv
// Host controller model driving the converter's strobe, select and read pins
`timescale 1ns/10ps
`default_nettype none

module sacr_host (
  input wire logic i_clk, // Core clock
  input wire logic i_busy, // Busy from device
  input wire logic [17:0] i_bus, // Resolved data bus
  output var logic o_conversion_start_n, // Start strobe
  output var logic o_cs_n, // Chip select
  output var logic o_rd_n, // Read strobe
  output var logic o_bus_width_select, // Width select
  output var logic o_byte_select // Byte select
);
  // ----------------------------------------
  // Pin timing bookkeeping
  // ----------------------------------------
  int quiet = 0;
  int idle = 0;
  logic [3:0] last_pins = 4'hC;

  initial
  begin
    o_conversion_start_n = 1'b1;
    o_cs_n = 1'b1;
    o_rd_n = 1'b1;
    o_bus_width_select = 1'b0;
    o_byte_select = 1'b0;
  end

  always @(posedge i_clk)
  begin
    quiet <= ({o_cs_n, o_rd_n, o_bus_width_select, o_byte_select} != last_pins) ? 0 : quiet + 1;
    last_pins <= {o_cs_n, o_rd_n, o_bus_width_select, o_byte_select};
    idle <= i_busy ? 0 : idle + 1;
  end

  task step;
    @(posedge i_clk);
    #1;
  endtask : step

  task set_pins(input logic cs, input logic rd, input logic w, input logic b);
    while (quiet < 13) step;
    // No read until the new result has settled
    while (!i_busy && idle < 8) step;
    o_cs_n = cs;
    o_rd_n = rd;
    o_bus_width_select = w;
    o_byte_select = b;
  endtask : set_pins

  task start(input bit abort, output int rise);
    rise = 0;
    // An abort must land inside its window, so it skips the waits
    while (!abort && (quiet < 32 || idle < 75)) step;
    o_conversion_start_n = 1'b0;
    for (int i = 1; i <= 12; i++)
    begin
      step;
      if (i_busy === 1'b1 && rise == 0) rise = i;
    end
    o_conversion_start_n = 1'b1;
    repeat (5) step;
  endtask : start

  task wait_done(output int n);
    n = 0;
    while (i_busy === 1'b1 && n < 1000)
    begin
      step;
      n++;
    end
  endtask : wait_done
endmodule : sacr_host
`default_nettype wire

// file: verification/sacr_top_tb.sv
// Self-checking bench for the converter handshake block
`timescale 1ns/10ps
`default_nettype none

module sacr_top_tb;
  localparam int CONV = 350;
  logic i_clk;
  logic i_rst_n;
  logic i_ce;
  logic i_sample_valid;
  logic [17:0] i_sample_data;
  wire logic cnv_n, cs_n, rd_n, wsel, bsel;
  logic o_sample_ready, o_busy, o_acquiring, o_data_oe;
  logic [17:0] o_data, cand, res;
  wire logic [17:0] data_bus;
  logic [31:0] seed;
  logic [17:0] q[$];
  int miscompares = 0, checks_done = 0, r, n, busy_run = 0, last_run = 0;

  assign data_bus = o_data_oe ? o_data : {18{1'bz}};

  sacr_top #(.CONV_CYC(CONV)) sacr_top_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
    .i_conversion_start_n(cnv_n), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_bus_width_select(wsel),
    .i_byte_select(bsel), .i_sample_valid(i_sample_valid), .i_sample_data(i_sample_data),
    .o_sample_ready(o_sample_ready), .o_busy(o_busy), .o_acquiring(o_acquiring),
    .o_data(o_data), .o_data_oe(o_data_oe));

  sacr_host sacr_host_inst (.i_clk(i_clk), .i_busy(o_busy), .i_bus(data_bus),
    .o_conversion_start_n(cnv_n), .o_cs_n(cs_n), .o_rd_n(rd_n),
    .o_bus_width_select(wsel), .o_byte_select(bsel));

  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  always @(posedge i_clk)
  begin
    busy_run <= o_busy ? busy_run + 1 : 0;
    if (!o_busy && busy_run != 0) last_run <= busy_run;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  function automatic logic [17:0] lanes(input logic [17:0] d, input logic [1:0] m);
    case (m)
      2'h0: return d;
      2'h1: return {d[9:2], 10'h3FF};
      2'h2: return {14'h3FFF, d[1:0], 2'h3};
      default: return {6'h3F, d[1:0], 10'h3FF};
    endcase
  endfunction : lanes

  task check(input logic [17:0] seen, input logic [17:0] exp, input string msg);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task step(input int k);
    repeat (k) sacr_host_inst.step;
  endtask : step

  task push(input logic [17:0] d);
    i_sample_valid = 1'b1;
    i_sample_data = d;
    if (o_sample_ready === 1'b1) q.push_back(d);
    step(1);
  endtask : push

  task run_conv;
    sacr_host_inst.start(1'b0, r);
    // Empty FIFO leaves the last sample in place
    cand = q.size() != 0 ? q.pop_front() : cand;
    check(r > 0 && r <= 11, 1'b1, "busy rise");
    sacr_host_inst.wait_done(n);
    step(6);
    check(last_run, CONV, "busy width");
    res = cand;
  endtask : run_conv

  task read_all(input logic [1:0] m);
    seed = xs(seed);
    sacr_host_inst.set_pins(1'b0, 1'b0, m[1], m[0]);
    step(5);
    check(data_bus, lanes(res, m), "read");
    sacr_host_inst.set_pins(1'b0, 1'b0, ~m[1], seed[0]);
    step(5);
    check(data_bus, lanes(res, {~m[1], seed[0]}), "lane change");
    sacr_host_inst.set_pins(1'b0, 1'b1, ~m[1], seed[0]);
    step(5);
    check(data_bus, {18{1'bz}}, "release");
    sacr_host_inst.set_pins(1'b1, 1'b1, 1'b0, 1'b0);
  endtask : read_all

  task finish_test;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    #200000;
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test;
  end

  initial
  begin
    i_rst_n = 1'b0;
    i_ce = 1'b1;
    i_sample_valid = 1'b0;
    i_sample_data = 18'h00000;
    seed = 32'h000093AC;
    repeat (10) @(posedge i_clk);
    #1 i_rst_n = 1'b1;
    check({o_busy, o_data_oe, o_sample_ready}, 3'h1, "reset");
    while (o_sample_ready === 1'b1 && q.size() < 40)
    begin
      seed = xs(seed);
      push(seed[17:0]);
    end
    push(18'h3C3C3);
    i_sample_valid = 1'b0;
    check(q.size(), 16, "fifo depth");
    $display("test fill done");
    for (int i = 0; i < 17; i++)
    begin
      run_conv;
      read_all(i[1:0]);
    end
    $display("test stream done");
    push(18'h2A5C3);
    i_sample_valid = 1'b0;
    sacr_host_inst.set_pins(1'b0, 1'b0, 1'b0, 1'b0);
    run_conv;
    check(data_bus, lanes(res, 2'h0), "data after busy");
    sacr_host_inst.set_pins(1'b0, 1'b1, 1'b0, 1'b0);
    sacr_host_inst.set_pins(1'b1, 1'b1, 1'b0, 1'b0);
    $display("test read through done");
    push(18'h15A3C);
    i_sample_valid = 1'b0;
    sacr_host_inst.start(1'b0, r);
    sacr_host_inst.set_pins(1'b0, 1'b1, 1'b0, 1'b0);
    sacr_host_inst.wait_done(n);
    step(2);
    check(n <= 8 && o_acquiring === 1'b1, 1'b1, "select abort");
    sacr_host_inst.set_pins(1'b0, 1'b0, 1'b0, 1'b0);
    step(5);
    check(data_bus, lanes(res, 2'h0), "result kept");
    sacr_host_inst.set_pins(1'b0, 1'b1, 1'b0, 1'b0);
    sacr_host_inst.start(1'b0, r);
    check(o_busy, 1'b1, "start from acquisition");
    sacr_host_inst.start(1'b1, r);
    sacr_host_inst.wait_done(n);
    check(n <= 8, 1'b1, "start abort");
    sacr_host_inst.set_pins(1'b1, 1'b1, 1'b0, 1'b0);
    sacr_host_inst.start(1'b0, r);
    step(140);
    // Frozen clock enable stretches busy by exactly the frozen cycles
    i_ce = 1'b0;
    step(10);
    i_ce = 1'b1;
    step(130);
    sacr_host_inst.set_pins(1'b0, 1'b1, 1'b0, 1'b0);
    sacr_host_inst.wait_done(n);
    step(6);
    check(last_run, CONV + 10, "late select ignored");
    $display("test abort done");
    finish_test;
  end
endmodule : sacr_top_tb
`default_nettype wire
